// *** htd_top.sv ***
// host timers, free-running counter and dropped-frame counter behind wishbone
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] run bit set starts timer, cleared halts
// [R2] run falling edge forces preload to ffff
// [R3] 16-bit preload read/write, resets ffff
// [R4] current count readable, resets ffff
// [R5] timer events raise host interrupts
// [R6] free counter from zero, steps each 25MHz
// [R7] free counter wraps at maximum
// [R8] low half read snapshots whole count
// [R9] free counter clear within 160 ns
// [R10] free counter runs in all power states
// [R11] drop counter increments per dropped frame
// [R12] reading drop counter returns and clears
// [R13] halfway crossing raises interrupt event
// [R14] timer counts down, reloads, pulses event
// [R15] events are one-cycle pulses setting sticky bits
module htd_top
    import htd_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [htd_pkg::ADR_W-1:0] I_WB_ADR,
    input wire logic [htd_pkg::SEL_W-1:0] I_WB_SEL,
    input wire logic [htd_pkg::DAT_W-1:0] I_WB_DAT,
    input wire logic I_RX_DROP,
    output logic [htd_pkg::DAT_W-1:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_IRQ,
    output logic O_TIMER_EVT,
    output logic O_HALF_EVT
);
    import htd_pkg::*;

    htd_state_t state_ff;
    htd_state_t nxt_state;
    logic tick;
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] adr;
    logic rd_drop;
    logic rd_fr_lo;

    function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] nw,
                                              input logic en);
        byte_merge = en ? nw : old;
    endfunction : byte_merge

    assign adr = {I_WB_ADR[7:2], 2'b00};
    assign tick = (state_ff.div == 2'(TICK_DIV - 1));
    assign acc = I_WB_CYC && I_WB_STB && !state_ff.ack;
    assign wr = acc && I_WB_WE;
    assign rd = acc && !I_WB_WE;
    assign rd_drop = rd && (adr == OFS_DROP);
    assign rd_fr_lo = rd && (adr == OFS_FREE_RUN) && (I_WB_SEL[1:0] != 2'b00);

    always_comb
    begin
        logic new_run;
        logic [15:0] new_load;
        logic [31:0] drop_base;
        new_run = 1'b0;
        new_load = 16'h0000;
        drop_base = 32'h0000_0000;
        nxt_state = state_ff;
        nxt_state.ack = acc;
        nxt_state.timer_evt = 1'b0;
        nxt_state.half_evt = 1'b0;
        // the counter never stops, there is no power-state gate on it
        nxt_state.div = tick ? 2'b00 : 2'(state_ff.div + 2'b01); // [R10]
        if (tick)
        begin
            nxt_state.free_run_tick_count = state_ff.free_run_tick_count + 32'h1; // [R6] [R7]
        end
        if (state_ff.run && tick)
        begin
            if (state_ff.timer_current_count == 16'h0000)
            begin
                nxt_state.timer_current_count = state_ff.timer_preload; // [R14]
                nxt_state.timer_evt = 1'b1; // [R14] [R15]
            end
            else
            begin
                nxt_state.timer_current_count = 16'(state_ff.timer_current_count - 16'h1);
            end
        end
        if (wr && adr == OFS_TIMER_CONFIG)
        begin
            new_run = I_WB_SEL[3] ? I_WB_DAT[RUN_BIT] : state_ff.run;
            new_load[7:0] = byte_merge(state_ff.timer_preload[7:0], I_WB_DAT[7:0], I_WB_SEL[0]);
            new_load[15:8] = byte_merge(state_ff.timer_preload[15:8], I_WB_DAT[15:8],
                                        I_WB_SEL[1]);
            nxt_state.timer_preload = new_load; // [R3]
            if (new_run && !state_ff.run)
            begin
                nxt_state.timer_current_count = new_load; // [R1]
            end
            if (!new_run && state_ff.run)
            begin
                nxt_state.timer_preload = PRELOAD_RST; // [R2]
            end
            nxt_state.run = new_run; // [R1]
        end
        // a frame dropped in the cycle of a clearing read is counted, not lost
        drop_base = rd_drop ? DROP_RST : state_ff.dropped_frame_count; // [R12]
        nxt_state.dropped_frame_count = drop_base + {31'h0, I_RX_DROP}; // [R11]
        if (I_RX_DROP && (drop_base + 32'h1) == DROP_HALF)
        begin
            nxt_state.half_evt = 1'b1; // [R13] [R15]
        end
        if (wr && adr == OFS_IRQ_STATUS && I_WB_SEL[0])
        begin
            nxt_state.sts = state_ff.sts & ~I_WB_DAT[IRQ_W-1:0];
        end
        if (wr && adr == OFS_IRQ_MASK && I_WB_SEL[0])
        begin
            nxt_state.mask = I_WB_DAT[IRQ_W-1:0];
        end
        // set wins over a write-one clear in the same cycle
        nxt_state.sts[IRQ_TIMER_BIT] = nxt_state.sts[IRQ_TIMER_BIT] | nxt_state.timer_evt; // [R5]
        nxt_state.sts[IRQ_HALF_BIT] = nxt_state.sts[IRQ_HALF_BIT] | nxt_state.half_evt; // [R13]
        nxt_state.irq = |(nxt_state.sts & nxt_state.mask); // [R5]
        if (rd_fr_lo)
        begin
            nxt_state.fr_snap = state_ff.free_run_tick_count; // [R8]
        end
        if (rd)
        begin
            unique case (adr)
                OFS_TIMER_CONFIG: nxt_state.rdat = {2'b00, state_ff.run, 13'h0000,
                                                    state_ff.timer_preload};
                OFS_TIMER_COUNT: nxt_state.rdat = {16'h0000, state_ff.timer_current_count}; // [R4]
                // upper-only read returns the snapshot so halves stay coherent
                OFS_FREE_RUN: nxt_state.rdat = rd_fr_lo ? state_ff.free_run_tick_count
                                                        : state_ff.fr_snap; // [R8]
                OFS_DROP: nxt_state.rdat = state_ff.dropped_frame_count; // [R12]
                OFS_IRQ_STATUS: nxt_state.rdat = {30'h0, state_ff.sts};
                OFS_IRQ_MASK: nxt_state.rdat = {30'h0, state_ff.mask};
                default: nxt_state.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            // reset acts in one edge, well inside the clearing allowance
            state_ff <= '0; // [R9]
            state_ff.free_run_tick_count <= FREE_RUN_RST; // [R6]
            state_ff.timer_preload <= PRELOAD_RST; // [R3]
            state_ff.timer_current_count <= COUNT_RST; // [R4]
            state_ff.dropped_frame_count <= DROP_RST; // [R11]
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign O_WB_DAT = state_ff.rdat;
    assign O_WB_ACK = state_ff.ack;
    assign O_IRQ = state_ff.irq;
    assign O_TIMER_EVT = state_ff.timer_evt;
    assign O_HALF_EVT = state_ff.half_evt;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);

    chk_ack_single: assert property (state_ff.ack |=> !state_ff.ack) // [R12]
        else $error("ack held for more than one cycle");
    chk_ack_follows: assert property (acc |=> state_ff.ack) // [R4]
        else $error("request not answered next cycle");
    chk_free_step: assert property (tick |=> state_ff.free_run_tick_count ==
                                    $past(state_ff.free_run_tick_count) + 32'h1) // [R6]
        else $error("free counter did not step on tick");
    chk_free_rate: assert property (tick |=> !tick [*3] ##1 tick) // [R6]
        else $error("tick not every four cycles");
    chk_drop_clear: assert property ((rd_drop && !I_RX_DROP) |=>
                                     state_ff.dropped_frame_count == 32'h0) // [R12]
        else $error("drop counter not cleared by read");
    chk_drop_inc: assert property ((I_RX_DROP && !rd_drop) |=> state_ff.dropped_frame_count ==
                                   $past(state_ff.dropped_frame_count) + 32'h1) // [R11]
        else $error("drop counter missed a frame");
    chk_stop_preload: assert property ((state_ff.run && !nxt_state.run) |=>
                                       state_ff.timer_preload == 16'hffff) // [R2]
        else $error("preload not forced on stop");
    chk_timer_reload: assert property ((state_ff.run && tick && // [R14]
                                        state_ff.timer_current_count == 16'h0) |=>
        (state_ff.timer_evt && state_ff.timer_current_count == $past(state_ff.timer_preload)))
        else $error("timer did not reload with event");
    chk_timer_halt: assert property ((!state_ff.run && !nxt_state.run) |=>
                                     $stable(state_ff.timer_current_count)) // [R1]
        else $error("halted timer moved");
    chk_half_event: assert property (state_ff.half_evt |->
                                     state_ff.dropped_frame_count == DROP_HALF) // [R13]
        else $error("halfway event at wrong count");
    chk_irq_level: assert property (O_IRQ == |(state_ff.sts & state_ff.mask)) // [R5]
        else $error("interrupt level mismatch");
    chk_fr_snap: assert property (rd_fr_lo |=> (state_ff.fr_snap ==
                                  $past(state_ff.free_run_tick_count) &&
                                  O_WB_DAT == $past(state_ff.free_run_tick_count))) // [R8]
        else $error("free counter snapshot wrong");
    chk_evt_pulse: assert property (state_ff.timer_evt |=> !state_ff.timer_evt) // [R15]
        else $error("timer event longer than a cycle");

    chk_run_start: assert property ( // [R1]
        (wr && adr == OFS_TIMER_CONFIG && I_WB_SEL[3] && I_WB_DAT[RUN_BIT])
        |=> state_ff.run)
        else $error("timer did not start");

    chk_run_stop: assert property ( // [R1]
        (wr && adr == OFS_TIMER_CONFIG && I_WB_SEL[3] && !I_WB_DAT[RUN_BIT])
        |=> !state_ff.run)
        else $error("timer did not halt");

    chk_count_step: assert property ( // [R14]
        (state_ff.run && tick && state_ff.timer_current_count != 16'h0000)
        |=> state_ff.timer_current_count == $past(state_ff.timer_current_count) - 16'h0001)
        else $error("running timer did not step down");

    chk_count_idle: assert property ( // [R14]
        (state_ff.run && !tick)
        |=> $stable(state_ff.timer_current_count))
        else $error("timer moved between ticks");

    chk_evt_early: assert property ( // [R14]
        (state_ff.run && tick && state_ff.timer_current_count != 16'h0000)
        |=> !state_ff.timer_evt)
        else $error("timer event before zero");

    chk_evt_quiet: assert property ( // [R14]
        !state_ff.run
        |=> !state_ff.timer_evt)
        else $error("timer event while halted");

    chk_preload_write: assert property ( // [R3]
        (wr && adr == OFS_TIMER_CONFIG && I_WB_SEL[0]
         && !(state_ff.run && I_WB_SEL[3] && !I_WB_DAT[RUN_BIT]))
        |=> state_ff.timer_preload[7:0] == $past(I_WB_DAT[7:0]))
        else $error("preload low byte not written");

    chk_preload_hold: assert property ( // [R3]
        !(wr && adr == OFS_TIMER_CONFIG)
        |=> $stable(state_ff.timer_preload))
        else $error("preload changed without a write");

    chk_count_ro: assert property ( // [R4]
        (wr && adr == OFS_TIMER_COUNT && !state_ff.run)
        |=> $stable(state_ff.timer_current_count))
        else $error("current count took a write");

    chk_rd_count: assert property ( // [R4]
        (rd && adr == OFS_TIMER_COUNT)
        |=> O_WB_DAT == {16'h0000, $past(state_ff.timer_current_count)})
        else $error("current count read wrong");

    chk_rd_config: assert property ( // [R3]
        (rd && adr == OFS_TIMER_CONFIG)
        |=> O_WB_DAT[15:0] == $past(state_ff.timer_preload))
        else $error("preload read wrong");

    chk_rd_drop: assert property ( // [R12]
        rd_drop
        |=> O_WB_DAT == $past(state_ff.dropped_frame_count))
        else $error("drop counter read wrong");

    chk_drop_race: assert property ( // [R12]
        (rd_drop && I_RX_DROP)
        |=> state_ff.dropped_frame_count == 32'h0000_0001)
        else $error("drop lost during clearing read");

    chk_drop_idle: assert property ( // [R11]
        (!I_RX_DROP && !rd_drop)
        |=> $stable(state_ff.dropped_frame_count))
        else $error("drop counter moved with no drop");

    chk_half_cause: assert property ( // [R13]
        (I_RX_DROP && !rd_drop && state_ff.dropped_frame_count == 32'h7fff_ffff)
        |=> state_ff.half_evt)
        else $error("halfway crossing missed");

    chk_half_pulse: assert property ( // [R15]
        state_ff.half_evt
        |=> !state_ff.half_evt)
        else $error("halfway event longer than a cycle");

    chk_half_quiet: assert property ( // [R13]
        !I_RX_DROP
        |=> !state_ff.half_evt)
        else $error("halfway event with no drop");

    chk_sts_timer: assert property ( // [R5]
        state_ff.timer_evt
        |-> state_ff.sts[IRQ_TIMER_BIT])
        else $error("timer status not set");

    chk_sts_half: assert property ( // [R13]
        state_ff.half_evt
        |-> state_ff.sts[IRQ_HALF_BIT])
        else $error("halfway status not set");

    chk_sts_clear: assert property ( // [R15]
        (wr && adr == OFS_IRQ_STATUS && I_WB_SEL[0] && I_WB_DAT[IRQ_TIMER_BIT]
         && !nxt_state.timer_evt)
        |=> !state_ff.sts[IRQ_TIMER_BIT])
        else $error("timer status not cleared");

    chk_sts_sticky: assert property ( // [R15]
        (state_ff.sts[IRQ_TIMER_BIT] && !(wr && adr == OFS_IRQ_STATUS))
        |=> state_ff.sts[IRQ_TIMER_BIT])
        else $error("timer status not sticky");

    chk_mask_write: assert property ( // [R5]
        (wr && adr == OFS_IRQ_MASK && I_WB_SEL[0])
        |=> state_ff.mask == $past(I_WB_DAT[IRQ_W-1:0]))
        else $error("mask not written");

    chk_mask_hold: assert property ( // [R5]
        !(wr && adr == OFS_IRQ_MASK)
        |=> $stable(state_ff.mask))
        else $error("mask changed without a write");

    chk_evt_irq: assert property ( // [R5]
        (state_ff.timer_evt && state_ff.mask[IRQ_TIMER_BIT])
        |-> O_IRQ)
        else $error("unmasked timer event gave no interrupt");

    chk_free_hold: assert property ( // [R6]
        !tick
        |=> $stable(state_ff.free_run_tick_count))
        else $error("free counter moved between ticks");

    chk_free_wrap: assert property ( // [R7]
        (tick && state_ff.free_run_tick_count == 32'hffff_ffff)
        |=> state_ff.free_run_tick_count == 32'h0000_0000)
        else $error("free counter did not wrap");

    chk_snap_hold: assert property ( // [R8]
        !rd_fr_lo
        |=> $stable(state_ff.fr_snap))
        else $error("snapshot changed without a low read");

    chk_snap_read: assert property ( // [R8]
        (rd && adr == OFS_FREE_RUN && !rd_fr_lo)
        |=> O_WB_DAT == $past(state_ff.fr_snap))
        else $error("upper read did not return snapshot");

    chk_rdat_hold: assert property ( // [R4]
        !rd
        |=> $stable(O_WB_DAT))
        else $error("read data changed without a read");

    chk_ack_idle: assert property ( // [R4]
        !acc
        |=> !state_ff.ack)
        else $error("ack with no request");

    chk_reset_free: assert property ( // [R9]
        $fell(I_SYS_RST)
        |-> (state_ff.free_run_tick_count == FREE_RUN_RST
             && state_ff.dropped_frame_count == DROP_RST))
        else $error("counters not clear after reset");

    chk_reset_timer: assert property ( // [R4]
        $fell(I_SYS_RST)
        |-> (state_ff.timer_current_count == COUNT_RST
             && state_ff.timer_preload == PRELOAD_RST && !state_ff.run))
        else $error("timer not at reset values");

    cov_timer_evt: cover property (state_ff.timer_evt && O_IRQ);
    cov_half_evt: cover property (state_ff.half_evt);
    cov_fr_pair: cover property (rd_fr_lo ##[1:20] (rd && adr == OFS_FREE_RUN && !rd_fr_lo));
    cov_drop_race: cover property (rd_drop && I_RX_DROP);
    cov_timer_stop: cover property (state_ff.run && !nxt_state.run);
endmodule : htd_top

// *** htd_pkg.sv ***
// constants and types shared by the host timers and drop counter block
package htd_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    localparam logic [7:0] OFS_TIMER_CONFIG = 8'h8c;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h90;
    localparam logic [7:0] OFS_FREE_RUN = 8'h9c;
    localparam logic [7:0] OFS_DROP = 8'ha0;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hb0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hb4;

    localparam int RUN_BIT = 29;
    localparam int IRQ_W = 2;
    localparam int IRQ_TIMER_BIT = 0;
    localparam int IRQ_HALF_BIT = 1;

    localparam logic [15:0] PRELOAD_RST = 16'hffff;
    localparam logic [15:0] COUNT_RST = 16'hffff;
    localparam logic [31:0] FREE_RUN_RST = 32'h0000_0000;
    localparam logic [31:0] DROP_RST = 32'h0000_0000;
    localparam logic [31:0] DROP_HALF = 32'h8000_0000;

    localparam int CLK_HZ = 100_000_000;
    localparam int FREE_RUN_HZ = 25_000_000;
    localparam int TICK_DIV = CLK_HZ / FREE_RUN_HZ;
    localparam int CLEAR_NS = 160;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
    // longest time rounds down, never below one cycle
    localparam int CLEAR_CYC = (CLEAR_NS / CLK_NS) < 1 ? 1 : (CLEAR_NS / CLK_NS);

    typedef struct packed {
        logic [1:0] div;
        logic [31:0] free_run_tick_count;
        logic [31:0] fr_snap;
        logic [15:0] timer_preload;
        logic run;
        logic [15:0] timer_current_count;
        logic [31:0] dropped_frame_count;
        logic [IRQ_W-1:0] sts;
        logic [IRQ_W-1:0] mask;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic timer_evt;
        logic half_evt;
    } htd_state_t;
endpackage : htd_pkg

// *** tb_htd_top.sv ***
// self-checking testbench for the host timers and drop counter block
`timescale 1ns/10ps
module tb_htd_top;
    import htd_pkg::*;
    logic clk;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [SEL_W-1:0] sel = '0;
    logic [DAT_W-1:0] wdat = '0;
    logic drop = 1'b0;
    logic [DAT_W-1:0] rdat;
    logic ack, irq, tevt, hevt;
    logic [31:0] v1, v2;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    htd_top uut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_RX_DROP(drop),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq), .O_TIMER_EVT(tevt), .O_HALF_EVT(hevt));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 4'hf, 32'h0, r);
        check(r, exp);
    endtask : rd_chk
    task automatic test_reset_and_preload();
        rd_chk(OFS_TIMER_CONFIG, 32'h0000_ffff);
        rd_chk(OFS_TIMER_COUNT, 32'h0000_ffff);
        rd_chk(OFS_DROP, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        // only the low byte lane is enabled, upper preload byte keeps its ones
        wb(1'b1, OFS_TIMER_CONFIG, 4'h1, 32'h2000_1234, v1);
        rd_chk(OFS_TIMER_CONFIG, 32'h0000_ff34);
    endtask : test_reset_and_preload
    task automatic test_timer();
        int i;
        wb(1'b1, OFS_TIMER_CONFIG, 4'hf, 32'h2000_0010, v1);
        wb(1'b0, OFS_TIMER_COUNT, 4'hf, 32'h0, v1);
        repeat (8) @(posedge clk);
        wb(1'b0, OFS_TIMER_COUNT, 4'hf, 32'h0, v2);
        check({31'h0, v1 != v2}, 32'h1);
        for (i = 0; i < 300 && tevt !== 1'b1; i++) @(posedge clk);
        check({31'h0, i < 300}, 32'h1);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, OFS_IRQ_MASK, 4'hf, 32'h1, v1);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, OFS_TIMER_CONFIG, 4'hf, 32'h0000_0010, v1);
        rd_chk(OFS_TIMER_CONFIG, 32'h0000_ffff);
        wb(1'b0, OFS_TIMER_COUNT, 4'hf, 32'h0, v1);
        repeat (12) @(posedge clk);
        rd_chk(OFS_TIMER_COUNT, v1);
        rd_chk(OFS_IRQ_STATUS, 32'h1);
        wb(1'b1, OFS_IRQ_STATUS, 4'hf, 32'h1, v1);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
    endtask : test_timer
    task automatic test_free_run();
        wb(1'b0, OFS_FREE_RUN, 4'hf, 32'h0, v1);
        repeat (40) @(posedge clk);
        wb(1'b0, OFS_FREE_RUN, 4'hf, 32'h0, v2);
        // 43 cycles between takings at four cycles a step
        check({31'h0, (v2 - v1) >= 32'h0a && (v2 - v1) <= 32'h0b}, 32'h1);
        wb(1'b0, OFS_FREE_RUN, 4'h3, 32'h0, v1);
        repeat (20) @(posedge clk);
        wb(1'b0, OFS_FREE_RUN, 4'hc, 32'h0, v2);
        check(v2, v1);
        wb(1'b0, OFS_FREE_RUN, 4'hf, 32'h0, v2);
        // 26 cycles between the snapshot and this live read
        check({31'h0, (v2 - v1) >= 32'h06 && (v2 - v1) <= 32'h07}, 32'h1);
    endtask : test_free_run
    task automatic test_drop();
        @(posedge clk);
        drop <= 1'b1;
        repeat (5) @(posedge clk);
        drop <= 1'b0;
        rd_chk(OFS_DROP, 32'h5);
        rd_chk(OFS_DROP, 32'h0);
        check({31'h0, hevt}, 32'h0);
    endtask : test_drop
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        test_reset_and_preload();
        test_timer();
        test_free_run();
        test_drop();
        end_sim();
    end
endmodule : tb_htd_top
